// [core/rsq_clk_div.v]
// Divider making the clock generator output and the bus clock phase.
`timescale 1ns/1ns
`default_nettype none
module rsq_clk_div (
  input wire clk_sys,
  input wire nrst,
  input wire src_tick,
  output wire clock_gen_output,
  output wire bus_phase
);
  reg [1:0] ph_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ph_q <= 2'h0;
    end else if (src_tick) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // Bit 0 is the source halved, bit 1 halves that again.
  assign clock_gen_output = ph_q[0];
  assign bus_phase = ph_q[1];
endmodule // rsq_clk_div
`default_nettype wire

// [core/rsq_regs.vh]
// Constants for the reset and bus clock sequencer.
`ifndef RSQ_REGS_VH
`define RSQ_REGS_VH
`define RSQ_CNT_W 13
`define RSQ_POR_CYC 4096
`define RSQ_STOP_LONG 4096
`define RSQ_STOP_SHORT 32
`define RSQ_DRV_CYC 32
`define RSQ_PIN_CYC 67
`define RSQ_PIN_POR_CYC 4163
`define RSQ_VEC_NORMAL 16'hfffe
`define RSQ_VEC_MONITOR 16'hfefe
`define RSQ_CAUSE_POR_VAL 8'h80
`define RSQ_CAUSE_POR 7
`define RSQ_CAUSE_PIN 6
`define RSQ_CAUSE_WDOG 5
`define RSQ_CAUSE_BADOP 4
`define RSQ_CAUSE_BADAD 3
`define RSQ_CAUSE_MODR 2
`define RSQ_CAUSE_LVI 1
`endif

// [core/rsq_sequencer.v]
// Reset and bus clock sequencer, top level.
`timescale 1ns/1ns
`default_nettype none
`include "rsq_regs.vh"
module rsq_sequencer #(
  parameter POR_CYC = `RSQ_POR_CYC,
  parameter STOP_LONG = `RSQ_STOP_LONG,
  parameter PIN_POR_CYC = `RSQ_PIN_POR_CYC
) (
  input wire clk_sys,
  input wire nrst,
  input wire pll_sel,
  input wire pll_vco_tick,
  input wire power_on_pulse,
  input wire brownout_reset,
  input wire watchdog_overflow,
  input wire bad_opcode_decode,
  input wire stop_instr,
  input wire wait_instr,
  input wire stop_enable_option,
  input wire short_stop_recovery_option,
  input wire wake_event,
  input wire opcode_fetch,
  input wire unmapped_addr,
  input wire monitor_entry_reset,
  input wire monitor_mode,
  input wire break_state,
  input wire rst_pin_in,
  input wire test_high_voltage_rst,
  input wire test_high_voltage_irq,
  input wire cause_clear,
  output wire rst_pin_out,
  output wire rst_pin_oe,
  output wire internal_reset_signal,
  output wire clock_gen_output,
  output wire bus_clock,
  output wire cpu_clock,
  output wire periph_clock,
  output wire aux_clock,
  output wire [15:0] reset_vector,
  output wire [7:0] reset_cause_register,
  output wire watchdog_disable
);
  localparam CW = `RSQ_CNT_W;
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_POR = 3'h1;
  localparam [2:0] ST_DRV = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_EXT = 3'h4;
  localparam [2:0] ST_STOP = 3'h5;
  localparam [2:0] ST_SREC = 3'h6;
  localparam [2:0] ST_WAIT = 3'h7;
  localparam integer POR_END_I = POR_CYC + `RSQ_DRV_CYC - 1;
  localparam integer POR_CLK_I = POR_CYC;
  localparam integer SLONG_END_I = STOP_LONG - 1;
  localparam integer SSHORT_END_I = `RSQ_STOP_SHORT - 1;
  localparam integer PIN_END_I = `RSQ_PIN_CYC - 1;
  localparam integer PIN_POR_END_I = PIN_POR_CYC - 1;
  localparam integer DRV_END_I = `RSQ_DRV_CYC - 1;
  // The end counts are cut to the counter width on purpose; larger values would wrap.
  localparam [CW-1:0] POR_END = POR_END_I[CW-1:0];
  localparam [CW-1:0] POR_CLK = POR_CLK_I[CW-1:0];
  localparam [CW-1:0] SLONG_END = SLONG_END_I[CW-1:0];
  localparam [CW-1:0] SSHORT_END = SSHORT_END_I[CW-1:0];
  localparam [CW-1:0] PIN_END = PIN_END_I[CW-1:0];
  localparam [CW-1:0] PIN_POR_END = PIN_POR_END_I[CW-1:0];
  localparam [5:0] DRV_END = DRV_END_I[5:0];

  wire pin_s;
  wire wdog_s;
  wire tvr_s;
  wire tvi_s;
  wire cgo;
  wire bus_ph;

  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg [5:0] dly_q;
  reg [5:0] dly_d;
  reg [CW-1:0] pcnt_q;
  reg por_prog_q;
  reg por_prog_d;
  reg [7:0] cause_q;
  reg [7:0] cause_d;
  reg oe_q;
  reg out_q;
  reg internal_reset_signal_q;
  reg cpu_clk_q;
  reg periph_clk_q;
  reg aux_clk_q;
  reg [15:0] vec_q;
  reg wdis_q;

  // The pin idles high through its pull-up, so the synchroniser's pin bit resets high; the other three bits reset low.
  rsq_sync #(.W(4), .INIT(4'h1)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({test_high_voltage_irq, test_high_voltage_rst, watchdog_overflow, rst_pin_in}),
    .dout({tvi_s, tvr_s, wdog_s, pin_s})
  );

  rsq_clk_div u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_tick(pll_sel ? pll_vco_tick : 1'b1),
    .clock_gen_output(cgo),
    .bus_phase(bus_ph)
  );

  wire pin_low = ~pin_s;
  wire bad_op = bad_opcode_decode | (stop_instr & ~stop_enable_option);
  wire bad_fetch = opcode_fetch & unmapped_addr;
  wire por_ev = power_on_pulse | brownout_reset;
  wire int_ev = wdog_s | bad_op | bad_fetch | monitor_entry_reset;
  wire stop_go = stop_instr & stop_enable_option;
  wire [CW-1:0] srec_end = short_stop_recovery_option ? SSHORT_END : SLONG_END;
  wire [CW-1:0] pin_end = por_prog_q ? PIN_POR_END : PIN_END;
  wire pin_hit = pin_low & (pcnt_q == pin_end);

  function clocks_on;
    input [2:0] s;
    input [CW-1:0] c;
    begin
      clocks_on = (s == ST_RUN) | (s == ST_WAIT) | (s == ST_DRV) |
                  (s == ST_HOLD) | (s == ST_EXT) | ((s == ST_POR) & (c >= POR_CLK));
    end
  endfunction

  always @* begin
    st_d = st_q;
    cnt_d = cnt_q + 1'b1;
    dly_d = dly_q;
    por_prog_d = por_prog_q;
    cause_d = cause_clear ? 8'h00 : cause_q;
    cause_d[`RSQ_CAUSE_PIN] = cause_d[`RSQ_CAUSE_PIN] | pin_hit;
    if (por_ev) begin
      st_d = ST_POR;
      cnt_d = {CW{1'b0}};
      dly_d = 6'h00;
      por_prog_d = 1'b1;
      if (power_on_pulse) begin
        cause_d = `RSQ_CAUSE_POR_VAL;
      end
      if (brownout_reset) begin
        cause_d[`RSQ_CAUSE_LVI] = 1'b1;
      end
    end else if (int_ev) begin
      st_d = ST_DRV;
      cnt_d = {CW{1'b0}};
      dly_d = 6'h00;
      cause_d[`RSQ_CAUSE_WDOG] = cause_d[`RSQ_CAUSE_WDOG] | wdog_s;
      cause_d[`RSQ_CAUSE_BADOP] = cause_d[`RSQ_CAUSE_BADOP] | bad_op;
      cause_d[`RSQ_CAUSE_BADAD] = cause_d[`RSQ_CAUSE_BADAD] | bad_fetch;
      cause_d[`RSQ_CAUSE_MODR] = cause_d[`RSQ_CAUSE_MODR] | monitor_entry_reset;
    end else begin
      case (st_q)
        ST_POR: begin
          if (cnt_q == POR_END) begin
            st_d = ST_HOLD;
            dly_d = 6'h00;
          end
        end
        ST_DRV: begin
          dly_d = dly_q + 6'h01;
          if (dly_q == DRV_END) begin
            st_d = ST_HOLD;
            dly_d = 6'h00;
          end
        end
        ST_HOLD: begin
          // The pin is seen through the synchroniser, so a released drive
          // still reads low for two cycles; the hold count waits for it.
          if (pin_low) begin
            dly_d = 6'h00;
          end else if (dly_q == DRV_END) begin
            st_d = ST_RUN;
            por_prog_d = 1'b0;
          end else begin
            dly_d = dly_q + 6'h01;
          end
        end
        ST_EXT: begin
          // A pin-only reset leaves the counter running.
          if (!pin_low) begin
            st_d = ST_HOLD;
            dly_d = 6'h00;
          end
        end
        ST_STOP: begin
          cnt_d = {CW{1'b0}};
          if (pin_low) begin
            st_d = ST_EXT;
          end else if (wake_event) begin
            st_d = ST_SREC;
          end
        end
        ST_SREC: begin
          if (pin_low) begin
            st_d = ST_EXT;
          end else if (cnt_q == srec_end) begin
            st_d = ST_RUN;
          end
        end
        ST_WAIT: begin
          if (pin_low) begin
            st_d = ST_EXT;
          end else if (wake_event) begin
            st_d = ST_RUN;
          end
        end
        default: begin
          if (pin_low) begin
            st_d = ST_EXT;
          end else if (stop_go) begin
            st_d = ST_STOP;
            cnt_d = {CW{1'b0}};
          end else if (wait_instr) begin
            st_d = ST_WAIT;
          end
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= ST_POR;
      cnt_q <= {CW{1'b0}};
      dly_q <= 6'h00;
      pcnt_q <= {CW{1'b0}};
      por_prog_q <= 1'b1;
      cause_q <= `RSQ_CAUSE_POR_VAL;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dly_q <= dly_d;
      por_prog_q <= por_prog_d;
      cause_q <= cause_d;
      if (!pin_low) begin
        pcnt_q <= {CW{1'b0}};
      end else if (pcnt_q != pin_end) begin
        pcnt_q <= pcnt_q + 1'b1;
      end
    end
  end

  // The pin, reset and gated clock outputs are registered from the next state so they line up with it.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      oe_q <= 1'b1;
      out_q <= 1'b0;
      internal_reset_signal_q <= 1'b1;
      cpu_clk_q <= 1'b0;
      periph_clk_q <= 1'b0;
      aux_clk_q <= 1'b0;
      vec_q <= `RSQ_VEC_NORMAL;
      wdis_q <= 1'b0;
    end else begin
      out_q <= 1'b0;
      oe_q <= (st_d == ST_POR) | (st_d == ST_DRV);
      internal_reset_signal_q <= (st_d == ST_POR) | (st_d == ST_DRV) |
                (st_d == ST_HOLD) | (st_d == ST_EXT);
      cpu_clk_q <= bus_ph & clocks_on(st_d, cnt_d) & (st_d != ST_WAIT);
      periph_clk_q <= bus_ph & clocks_on(st_d, cnt_d);
      aux_clk_q <= cgo & clocks_on(st_d, cnt_d);
      vec_q <= monitor_mode ? `RSQ_VEC_MONITOR : `RSQ_VEC_NORMAL;
      // Only the decoded test voltage can disable, so pin noise cannot.
      wdis_q <= (monitor_mode & (tvr_s | tvi_s)) | (break_state & tvr_s);
    end
  end

  assign rst_pin_out = out_q;
  assign rst_pin_oe = oe_q;
  assign internal_reset_signal = internal_reset_signal_q;
  assign clock_gen_output = cgo;
  assign bus_clock = bus_ph;
  assign cpu_clock = cpu_clk_q;
  assign periph_clock = periph_clk_q;
  assign aux_clock = aux_clk_q;
  assign reset_vector = vec_q;
  assign reset_cause_register = cause_q;
  assign watchdog_disable = wdis_q;
endmodule // rsq_sequencer
`default_nettype wire

// [core/rsq_sync.v]
// Two flip-flop synchroniser for pin level inputs.
`timescale 1ns/1ns
`default_nettype none
module rsq_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys,
  input wire nrst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // rsq_sync
`default_nettype wire

// [tb/rsq_pin_model.sv]
// External reset line with pull-up and an optional outside driver.
`timescale 1ns/1ns
`default_nettype none
module rsq_pin_model (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic ext_low,
  output logic pin_level
);
  // Released lines go to the pull-up level, never hold the last value.
  assign pin_level = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule // rsq_pin_model
`default_nettype wire

// [tb/rsq_sequencer_properties.sv]
// Checker for the reset and bus clock sequencer.
`timescale 1ns/1ns
`default_nettype none
module rsq_sequencer_properties #(
  parameter POR_CYC = 4096
) (
  input wire clk_sys,
  input wire nrst,
  input wire power_on_pulse,
  input wire bad_opcode_decode,
  input wire opcode_fetch,
  input wire unmapped_addr,
  input wire monitor_mode,
  input wire break_state,
  input wire test_high_voltage_rst,
  input wire test_high_voltage_irq,
  input wire cpu_clock,
  input wire periph_clock,
  input wire aux_clock,
  input wire rst_pin_oe,
  input wire internal_reset_signal,
  input wire [15:0] reset_vector,
  input wire [7:0] reset_cause_register,
  input wire watchdog_disable
);
  logic [13:0] run_q;
  logic seen_q;
  wire wd_x;
  assign wd_x = (monitor_mode & (test_high_voltage_rst | test_high_voltage_irq))
    | (break_state & test_high_voltage_rst);
  // The drive length is only judged once a low phase was seen after reset.
  always @(posedge clk_sys) begin
    run_q <= rst_pin_oe ? run_q + 14'h1 : 14'h0;
    seen_q <= nrst & (seen_q | !rst_pin_oe);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_BADOP: assert property (bad_opcode_decode && !power_on_pulse |=>
    rst_pin_oe && internal_reset_signal && reset_cause_register[4]) else $error("bad opcode");
  AST_FETCH: assert property (opcode_fetch && unmapped_addr && !power_on_pulse |=>
    reset_cause_register[3]) else $error("bad fetch flag");
  AST_POR: assert property (power_on_pulse |=>
    reset_cause_register == 8'h80 && rst_pin_oe) else $error("power-on cause");
  AST_POR_CLK: assert property (power_on_pulse |=>
    (!cpu_clock && !periph_clock && !aux_clock) [*8]) else $error("clocks during power-on");
  AST_OE_LEN: assert property ($fell(rst_pin_oe) && seen_q |->
    run_q == 32 || run_q == POR_CYC + 32) else $error("pin drive length");
  AST_INTERNAL_RESET_SIGNAL_HOLD: assert property ($fell(internal_reset_signal) |->
    $past(rst_pin_oe, 30) == 1'b0) else $error("reset hold too short");
  AST_VEC: assert property (1'b1 |=>
    reset_vector == ($past(monitor_mode) ? 16'hfefe : 16'hfffe)) else $error("vector");
  AST_WDOG_ON: assert property (wd_x [*4] |-> watchdog_disable)
    else $error("watchdog not disabled");
  AST_WDOG_OFF: assert property ((!wd_x) [*4] |-> !watchdog_disable)
    else $error("watchdog disabled");
endmodule // rsq_sequencer_properties
bind rsq_sequencer rsq_sequencer_properties #(.POR_CYC(POR_CYC)) i_chk (.clk_sys, .nrst,
  .power_on_pulse, .bad_opcode_decode, .opcode_fetch, .unmapped_addr, .monitor_mode,
  .break_state, .test_high_voltage_rst, .test_high_voltage_irq, .cpu_clock, .periph_clock,
  .aux_clock, .rst_pin_oe,
  .internal_reset_signal, .reset_vector, .reset_cause_register, .watchdog_disable);
`default_nettype wire

// [tb/rsq_sequencer_tb.sv]
// Self-checking testbench for the reset and bus clock sequencer.
`timescale 1ns/1ns
`default_nettype none
module rsq_sequencer_tb;
  logic clk_sys = 0, nrst = 0, pll_sel = 0, pll_vco_tick = 0, power_on_pulse = 0;
  logic brownout_reset = 0, watchdog_overflow = 0, bad_opcode_decode = 0, stop_instr = 0;
  logic wait_instr = 0, stop_enable_option = 1, short_stop_recovery_option = 1;
  logic wake_event = 0, opcode_fetch = 0, unmapped_addr = 0, monitor_entry_reset = 0;
  logic monitor_mode = 0, break_state = 0, test_high_voltage_rst = 0, cause_clear = 0;
  logic test_high_voltage_irq = 0, ext_low = 0;
  wire rst_pin_in, rst_pin_out, rst_pin_oe, internal_reset_signal, clock_gen_output;
  wire bus_clock, cpu_clock, periph_clock, aux_clock, watchdog_disable;
  wire [15:0] reset_vector;
  wire [7:0] reset_cause_register;
  int err_count = 0, check_count = 0, nb, ng, k;
  rsq_sequencer #(.POR_CYC(64), .STOP_LONG(64), .PIN_POR_CYC(131)) i_dut (.clk_sys, .nrst,
    .pll_sel, .pll_vco_tick, .power_on_pulse, .brownout_reset, .watchdog_overflow,
    .bad_opcode_decode, .stop_instr, .wait_instr, .stop_enable_option,
    .short_stop_recovery_option, .wake_event, .opcode_fetch, .unmapped_addr,
    .monitor_entry_reset, .monitor_mode, .break_state, .rst_pin_in, .test_high_voltage_rst,
    .test_high_voltage_irq, .cause_clear, .rst_pin_out, .rst_pin_oe, .internal_reset_signal,
    .clock_gen_output, .bus_clock, .cpu_clock, .periph_clock, .aux_clock, .reset_vector,
    .reset_cause_register, .watchdog_disable);
  rsq_pin_model i_pin (.pin_oe(rst_pin_oe), .pin_out(rst_pin_out), .ext_low,
    .pin_level(rst_pin_in));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pll_vco_tick <= ~pll_vco_tick;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Waits a few cycles so a freshly taken request has raised reset first.
  task automatic settle;
    int i;
    i = 0;
    cyc(4);
    while (internal_reset_signal !== 1'b0 && i < 9000) begin
      @(negedge clk_sys);
      i++;
    end
    chk(i < 9000, 1'b1);
  endtask
  task automatic fire(input int s);
    @(posedge clk_sys);
    case (s)
      0: watchdog_overflow <= 1;
      1: bad_opcode_decode <= 1;
      2: {opcode_fetch, unmapped_addr} <= 2'b11;
      3: monitor_entry_reset <= 1;
      4: brownout_reset <= 1;
      5: stop_instr <= 1;
      6: wait_instr <= 1;
      7: wake_event <= 1;
      8: cause_clear <= 1;
      default: power_on_pulse <= 1;
    endcase
    @(posedge clk_sys);
    {watchdog_overflow, bad_opcode_decode, opcode_fetch, unmapped_addr} <= 4'h0;
    {monitor_entry_reset, brownout_reset, stop_instr, wait_instr} <= 4'h0;
    {wake_event, cause_clear, power_on_pulse} <= 3'h0;
  endtask
  // Counts rising edges of both generated clocks over forty cycles.
  task automatic rate;
    logic pb, pg;
    int i;
    nb = 0;
    ng = 0;
    @(negedge clk_sys);
    pb = bus_clock;
    pg = clock_gen_output;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      nb += int'(bus_clock && !pb);
      ng += int'(clock_gen_output && !pg);
      pb = bus_clock;
      pg = clock_gen_output;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(4);
    nrst <= 1;
    cyc(8);
    @(negedge clk_sys);
    chk({cpu_clock, periph_clock, aux_clock, rst_pin_oe, internal_reset_signal}, 5'h3);
    settle;
    chk(reset_cause_register, 8'h80);
    chk(reset_vector, 16'hfffe);
    rate;
    chk(nb, 10);
    chk(ng, 20);
    @(posedge clk_sys);
    pll_sel <= 1;
    cyc(12);
    rate;
    chk(nb, 5);
    chk(ng, 10);
    $display("test clocks done");
    for (k = 0; k < 5; k++) begin
      fire(8);
      fire(k);
      cyc(4);
      @(negedge clk_sys);
      chk({rst_pin_oe, rst_pin_out, internal_reset_signal}, 3'b101);
      settle;
      chk(reset_cause_register, 8'h20 >> k);
    end
    fire(9);
    settle;
    chk(reset_cause_register, 8'h80);
    fire(8);
    @(posedge clk_sys);
    unmapped_addr <= 1;
    cyc(6);
    unmapped_addr <= 0;
    @(negedge clk_sys);
    chk({internal_reset_signal, reset_cause_register}, 9'h0);
    @(posedge clk_sys);
    stop_enable_option <= 0;
    fire(5);
    settle;
    chk(reset_cause_register, 8'h10);
    $display("test sources done");
    for (k = 70; k > 0; k -= 30) begin
      fire(8);
      stop_enable_option <= 1;
      ext_low <= 1;
      cyc(k);
      ext_low <= 0;
      settle;
      chk(reset_cause_register, k > 67 ? 8'h40 : 8'h0);
    end
    $display("test pin done");
    for (k = 32; k < 65; k += 32) begin
      fire(8);
      short_stop_recovery_option <= k == 32;
      fire(5);
      cyc(10);
      chk({aux_clock, cpu_clock, periph_clock}, 3'h0);
      fire(7);
      nb = 0;
      while (periph_clock !== 1'b1 && nb < 200) begin
        @(negedge clk_sys);
        nb++;
      end
      chk(nb >= k - 4 && nb <= k + 6, 1'b1);
    end
    fire(6);
    ng = 0;
    nb = 0;
    k = 0;
    repeat (16) begin
      @(negedge clk_sys);
      ng += int'(cpu_clock !== 1'b0);
      nb += int'(periph_clock === 1'b1);
      k += int'(aux_clock === 1'b1);
    end
    chk(ng, 0);
    chk(nb, 8);
    chk(k, 8);
    fire(7);
    $display("test low power done");
    monitor_mode <= 1;
    test_high_voltage_irq <= 1;
    cyc(6);
    chk(watchdog_disable, 1'b1);
    chk(reset_vector, 16'hfefe);
    monitor_mode <= 0;
    break_state <= 1;
    cyc(6);
    chk(watchdog_disable, 1'b0);
    test_high_voltage_rst <= 1;
    cyc(6);
    chk(watchdog_disable, 1'b1);
    $display("test watchdog done");
    print_verdict;
  end
  initial begin
    cyc(20000);
    err_count++;
    print_verdict;
  end
endmodule // rsq_sequencer_tb
`default_nettype wire
